// ===== rtl/cap_pkg.sv
// Shared constants and types of the configuration access ports.
// Assumes a fabric clock domain and a separate test-clock domain.
package cap_pkg;

	// Instruction register and its codes
	localparam int              IR_W       = 6;
	localparam logic [IR_W-1:0] OP_EXTEST  = 6'h00;
	localparam logic [IR_W-1:0] OP_SAMPLE  = 6'h01;
	localparam logic [IR_W-1:0] OP_CFG_OUT = 6'h04;
	localparam logic [IR_W-1:0] OP_CFG_IN  = 6'h05;
	localparam logic [IR_W-1:0] OP_IDCODE  = 6'h09;
	localparam logic [IR_W-1:0] OP_BYPASS  = 6'h3F;
	localparam logic [IR_W-1:0] IR_CAPTURE = 6'h01;

	// Internal port handshake timing in config clock cycles
	localparam int BUSY_CYC  = 2;
	localparam int ABORT_CYC = 4;

	// Status byte layout
	localparam int         ST_CFGERR_N  = 7;
	localparam int         ST_ALIGNED   = 6;
	localparam int         ST_RB_ACTIVE = 5;
	localparam int         ST_NO_ABORT  = 4;
	localparam logic [3:0] ST_FILL      = 4'hF;

	// Test port controller states
	typedef enum logic [3:0] {
		TAP_RESET  = 4'h0,
		TAP_IDLE   = 4'h1,
		TAP_SEL_DR = 4'h2,
		TAP_CAP_DR = 4'h3,
		TAP_SH_DR  = 4'h4,
		TAP_EX1_DR = 4'h5,
		TAP_PA_DR  = 4'h6,
		TAP_EX2_DR = 4'h7,
		TAP_UP_DR  = 4'h8,
		TAP_SEL_IR = 4'h9,
		TAP_CAP_IR = 4'hA,
		TAP_SH_IR  = 4'hB,
		TAP_EX1_IR = 4'hC,
		TAP_PA_IR  = 4'hD,
		TAP_EX2_IR = 4'hE,
		TAP_UP_IR  = 4'hF
	} cap_tap_e;

	// Internal port handshake states
	typedef enum logic [1:0] {
		PORT_IDLE  = 2'h0,
		PORT_BUSY  = 2'h1,
		PORT_READY = 2'h2,
		PORT_ABORT = 2'h3
	} cap_port_e;

	// Data register selected by the instruction
	typedef enum logic [1:0] {
		DR_BYPASS = 2'h0,
		DR_ID     = 2'h1,
		DR_BSR    = 2'h2,
		DR_CFG    = 2'h3
	} cap_dr_e;

	// Controller strobes decoded from the state
	typedef struct packed {
		logic tlr;
		logic cap_ir;
		logic sh_ir;
		logic upd_ir;
		logic cap_dr;
		logic sh_dr;
		logic upd_dr;
	} cap_tap_ctl_s;

	// Internal port request from fabric
	typedef struct packed {
		logic       sel_n;
		logic       read_not_write;
		logic [7:0] wdata;
	} cap_cfg_req_s;

	// Internal port answer to fabric
	typedef struct packed {
		logic       busy;
		logic [7:0] rdata;
	} cap_cfg_rsp_s;

endpackage

// ===== rtl/cap_tap_fsm.sv
// Sixteen-state test port controller on the test clock.
// Assumes the mode-select pin is valid at each rising test-clock edge.
`timescale 1ns/1ps
module cap_tap_fsm (
	input  wire logic            tck,
	input  wire logic            resetn,
	input  wire logic            tms,
	output cap_pkg::cap_tap_e    state_q,
	output cap_pkg::cap_tap_ctl_s ctl
);

	// Next state from current state and mode-select level
	function automatic cap_pkg::cap_tap_e step(cap_pkg::cap_tap_e s,
		logic m);
		unique case (s)
			cap_pkg::TAP_RESET:  step = m ? cap_pkg::TAP_RESET  : cap_pkg::TAP_IDLE;
			cap_pkg::TAP_IDLE:   step = m ? cap_pkg::TAP_SEL_DR : cap_pkg::TAP_IDLE;
			cap_pkg::TAP_SEL_DR: step = m ? cap_pkg::TAP_SEL_IR : cap_pkg::TAP_CAP_DR;
			cap_pkg::TAP_CAP_DR: step = m ? cap_pkg::TAP_EX1_DR : cap_pkg::TAP_SH_DR;
			cap_pkg::TAP_SH_DR:  step = m ? cap_pkg::TAP_EX1_DR : cap_pkg::TAP_SH_DR;
			cap_pkg::TAP_EX1_DR: step = m ? cap_pkg::TAP_UP_DR  : cap_pkg::TAP_PA_DR;
			cap_pkg::TAP_PA_DR:  step = m ? cap_pkg::TAP_EX2_DR : cap_pkg::TAP_PA_DR;
			cap_pkg::TAP_EX2_DR: step = m ? cap_pkg::TAP_UP_DR  : cap_pkg::TAP_SH_DR;
			cap_pkg::TAP_UP_DR:  step = m ? cap_pkg::TAP_SEL_DR : cap_pkg::TAP_IDLE;
			cap_pkg::TAP_SEL_IR: step = m ? cap_pkg::TAP_RESET  : cap_pkg::TAP_CAP_IR;
			cap_pkg::TAP_CAP_IR: step = m ? cap_pkg::TAP_EX1_IR : cap_pkg::TAP_SH_IR;
			cap_pkg::TAP_SH_IR:  step = m ? cap_pkg::TAP_EX1_IR : cap_pkg::TAP_SH_IR;
			cap_pkg::TAP_EX1_IR: step = m ? cap_pkg::TAP_UP_IR  : cap_pkg::TAP_PA_IR;
			cap_pkg::TAP_PA_IR:  step = m ? cap_pkg::TAP_EX2_IR : cap_pkg::TAP_PA_IR;
			cap_pkg::TAP_EX2_IR: step = m ? cap_pkg::TAP_UP_IR  : cap_pkg::TAP_SH_IR;
			cap_pkg::TAP_UP_IR:  step = m ? cap_pkg::TAP_SEL_DR : cap_pkg::TAP_IDLE;
		endcase
	endfunction

	// State register; power-up lands in test-logic-reset
	always_ff @(posedge tck or negedge resetn) begin
		if (!resetn) begin
			state_q <= cap_pkg::TAP_RESET;
		end else begin
			state_q <= step(state_q, tms);
		end
	end

	// Strobes for test-logic-reset and the two scan sequences
	assign ctl.tlr    = (state_q == cap_pkg::TAP_RESET);
	assign ctl.cap_ir = (state_q == cap_pkg::TAP_CAP_IR);
	assign ctl.sh_ir  = (state_q == cap_pkg::TAP_SH_IR);
	assign ctl.upd_ir = (state_q == cap_pkg::TAP_UP_IR);
	assign ctl.cap_dr = (state_q == cap_pkg::TAP_CAP_DR);
	assign ctl.sh_dr  = (state_q == cap_pkg::TAP_SH_DR);
	assign ctl.upd_dr = (state_q == cap_pkg::TAP_UP_DR);

	// Helper: run of consecutive high mode-select samples
	logic [2:0] ones_q;
	always_ff @(posedge tck or negedge resetn) begin
		if (!resetn) begin
			ones_q <= 3'h0;
		end else if (!tms) begin
			ones_q <= 3'h0;
		end else if (ones_q != 3'h5) begin
			ones_q <= ones_q + 3'h1;
		end
	end

	AST_FIVE_ONES_RESET: assert property (@(posedge tck)
		disable iff (!resetn)
		ones_q == 3'h5 |-> state_q == cap_pkg::TAP_RESET)
		else $error("five high mode-select edges did not reset");

	AST_SHIFT_HOLDS: assert property (@(posedge tck)
		disable iff (!resetn) state_q == cap_pkg::TAP_SH_DR && !tms |=>
		state_q == cap_pkg::TAP_SH_DR)
		else $error("shift state left with mode-select low");

endmodule

// ===== rtl/cap_top.sv
// Configuration access ports: internal byte port and boundary-scan port.
// Assumes fabric drives the internal port on clock; tck is a free domain.
`timescale 1ns/1ps
module cap_top #(
	parameter int          DEPTH    = 16,
	parameter int          BSR_LEN  = 8,
	parameter int          CFG_DR_W = 64,
	parameter logic [31:0] ID_VALUE = 32'h0A5C_0001 // Arbitrary value
) (
	input  wire logic                 clock,
	input  wire logic                 resetn,
	input  cap_pkg::cap_cfg_req_s     cfg_req,
	output cap_pkg::cap_cfg_rsp_s     cfg_rsp,
	input  wire logic                 config_done,
	input  wire logic                 retain_external_port_bit,
	output logic                      ext_port_enable,
	input  wire logic                 tck,
	input  wire logic                 tms,
	input  wire logic                 tdi,
	output logic                      tdo_o,
	output logic                      tdo_oe,
	input  wire logic [BSR_LEN-1:0]   bsr_pins_in,
	output logic      [BSR_LEN-1:0]   bsr_update
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Refuse sizes and ID values the logic cannot serve
	if (DEPTH < 2 || BSR_LEN < 1 || CFG_DR_W < 8 || !ID_VALUE[0]) begin : g_chk
		$error("cap_top: unsupported parameter value");
	end

	// ---------------- Fabric clock domain ----------------

	// Pin levels pass two flip-flops before use
	logic [1:0] pin_s1_q;
	logic [1:0] pin_s2_q;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			pin_s1_q <= 2'h0;
			pin_s2_q <= 2'h0;
		end else begin
			pin_s1_q <= {retain_external_port_bit, config_done};
			pin_s2_q <= pin_s1_q;
		end
	end

	logic port_enabled;
	logic sel;
	assign port_enabled = !(pin_s2_q[0] && pin_s2_q[1]);
	assign sel          = !cfg_req.sel_n && port_enabled;

	// External port keeps working unless internal port owns it after done
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ext_port_enable <= 1'b1;
		end else begin
			ext_port_enable <= !pin_s2_q[0] || pin_s2_q[1];
		end
	end

	// Test-domain config byte arrives as toggle plus stable data
	logic [2:0] jtg_tog_s_q;
	logic       jtg_evt;
	logic       jtg_tog_q;
	logic [7:0] jtg_hold_q;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			jtg_tog_s_q <= 3'h0;
		end else begin
			jtg_tog_s_q <= {jtg_tog_s_q[1:0], jtg_tog_q};
		end
	end
	assign jtg_evt = jtg_tog_s_q[2] ^ jtg_tog_s_q[1];

	// Port handshake: busy after select, ready, abort on direction change
	cap_pkg::cap_port_e st_q;
	logic [1:0]         cnt_q;
	logic               rnw_q;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_q  <= cap_pkg::PORT_IDLE;
			cnt_q <= 2'h0;
			rnw_q <= 1'b0;
		end else if (st_q == cap_pkg::PORT_ABORT) begin
			// Abort runs out even if deselected
			if (cnt_q == 2'h0) begin
				st_q <= cap_pkg::PORT_IDLE;
			end else begin
				cnt_q <= cnt_q - 2'h1;
			end
			rnw_q <= cfg_req.read_not_write;
		end else if (!sel) begin
			st_q <= cap_pkg::PORT_IDLE;
		end else if (st_q != cap_pkg::PORT_IDLE &&
			cfg_req.read_not_write != rnw_q) begin
			st_q  <= cap_pkg::PORT_ABORT;
			cnt_q <= 2'(cap_pkg::ABORT_CYC - 1);
			rnw_q <= cfg_req.read_not_write;
		end else begin
			unique case (st_q)
				cap_pkg::PORT_IDLE: begin
					st_q  <= cap_pkg::PORT_BUSY;
					cnt_q <= 2'(cap_pkg::BUSY_CYC - 1);
					rnw_q <= cfg_req.read_not_write;
				end
				cap_pkg::PORT_BUSY: begin
					if (cnt_q == 2'h0) begin
						st_q <= cap_pkg::PORT_READY;
					end else begin
						cnt_q <= cnt_q - 2'h1;
					end
				end
				default: begin
					st_q <= cap_pkg::PORT_READY;
				end
			endcase
		end
	end

	// Status flags seen through abort bytes and the test config register
	logic aligned_q;
	logic wr_en;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			aligned_q <= 1'b0;
		end else if (wr_en) begin
			aligned_q <= 1'b1; // A byte landing with an abort clear wins
		end else if (st_q == cap_pkg::PORT_ABORT) begin
			aligned_q <= 1'b0;
		end
	end

	logic [7:0] status;
	always_comb begin
		status                        = {4'h0, cap_pkg::ST_FILL};
		status[cap_pkg::ST_CFGERR_N]  = 1'b1;
		status[cap_pkg::ST_ALIGNED]   = aligned_q;
		status[cap_pkg::ST_RB_ACTIVE] = (st_q == cap_pkg::PORT_READY) & rnw_q;
		status[cap_pkg::ST_NO_ABORT]  = (st_q != cap_pkg::PORT_ABORT);
	end

	// Configuration byte store; test-port bytes win since both at once
	// is a misuse
	logic [7:0]    mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic          port_wr;
	logic          rd_en;
	logic [7:0]    wr_byte;
	assign port_wr = (st_q == cap_pkg::PORT_READY) && sel &&
		!cfg_req.read_not_write && !rnw_q;
	assign wr_en   = port_wr || jtg_evt;
	assign wr_byte = jtg_evt ? jtg_hold_q : cfg_req.wdata;

	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_ptr_q] <= wr_byte;
		end
	end

	// Pointers wrap around the store
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
		end else begin
			if (wr_en) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (rd_en) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
		end
	end

	// Read bytes, or the status byte while an abort runs in either direction
	logic [7:0] rdata_q;
	assign rd_en = (st_q == cap_pkg::PORT_READY) && sel &&
		cfg_req.read_not_write && rnw_q;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
		end else if (st_q == cap_pkg::PORT_ABORT) begin
			rdata_q <= status;
		end else if (rd_en) begin
			rdata_q <= mem[rd_ptr_q];
		end
	end

	// Deselect releases outputs at once, so gating is combinational
	logic drive_rd;
	assign drive_rd      = sel && cfg_req.read_not_write;
	assign cfg_rsp.rdata = drive_rd ? rdata_q : 8'h00;
	assign cfg_rsp.busy  = sel && (st_q == cap_pkg::PORT_BUSY ||
		(st_q == cap_pkg::PORT_ABORT && rnw_q));

	AST_BUSY_AFTER_SELECT: assert property (@(posedge clock)
		disable iff (!resetn)
		st_q == cap_pkg::PORT_IDLE && sel ##1 sel |-> cfg_rsp.busy)
		else $error("busy not raised after select");

	AST_ABORT_FOUR: assert property (@(posedge clock)
		disable iff (!resetn) $rose(st_q == cap_pkg::PORT_ABORT) |->
		(st_q == cap_pkg::PORT_ABORT)[*4] ##1 st_q != cap_pkg::PORT_ABORT)
		else $error("abort did not last four cycles");

	AST_DONE_RETAIN_OFF: assert property (@(posedge clock)
		disable iff (!resetn)
		pin_s2_q == 2'h3 |-> (!cfg_rsp.busy && !wr_en) || jtg_evt)
		else $error("internal port active while disabled");

	AST_DESELECT_RELEASE: assert property (@(posedge clock)
		disable iff (!resetn)
		cfg_req.sel_n |-> !cfg_rsp.busy && cfg_rsp.rdata == 8'h00)
		else $error("outputs not released on deselect");

	// ---------------- Test clock domain ----------------

	cap_pkg::cap_tap_e     tap_st;
	cap_pkg::cap_tap_ctl_s ctl;
	cap_tap_fsm u_tap (
		.tck     (tck),
		.resetn  (resetn),
		.tms     (tms),
		.state_q (tap_st),
		.ctl     (ctl)
	);

	// Status flags are independent levels, synced bit by bit
	logic [7:0] st_s1_q;
	logic [7:0] st_s2_q;
	always_ff @(posedge tck or negedge resetn) begin
		if (!resetn) begin
			st_s1_q <= 8'h00;
			st_s2_q <= 8'h00;
		end else begin
			st_s1_q <= status;
			st_s2_q <= st_s1_q;
		end
	end

	// Instruction register: capture, shift, update; reset picks ident
	logic [cap_pkg::IR_W-1:0] ir_sr_q;
	logic [cap_pkg::IR_W-1:0] ir_q;
	always_ff @(posedge tck or negedge resetn) begin
		if (!resetn) begin
			ir_sr_q <= '0;
			ir_q    <= cap_pkg::OP_IDCODE;
		end else begin
			if (ctl.cap_ir) begin
				ir_sr_q <= cap_pkg::IR_CAPTURE;
			end else if (ctl.sh_ir) begin
				ir_sr_q <= {tdi, ir_sr_q[cap_pkg::IR_W-1:1]};
			end
			if (ctl.tlr) begin
				ir_q <= cap_pkg::OP_IDCODE;
			end else if (ctl.upd_ir) begin
				ir_q <= ir_sr_q;
			end
		end
	end

	// Instruction decoder; unknown codes fall to bypass
	function automatic cap_pkg::cap_dr_e dr_of(
		logic [cap_pkg::IR_W-1:0] op);
		unique case (op)
			cap_pkg::OP_IDCODE:  dr_of = cap_pkg::DR_ID;
			cap_pkg::OP_EXTEST,
			cap_pkg::OP_SAMPLE:  dr_of = cap_pkg::DR_BSR;
			cap_pkg::OP_CFG_IN,
			cap_pkg::OP_CFG_OUT: dr_of = cap_pkg::DR_CFG;
			default:             dr_of = cap_pkg::DR_BYPASS;
		endcase
	endfunction

	cap_pkg::cap_dr_e dr_sel;
	assign dr_sel = dr_of(ir_q);

	// Data registers: bypass, identification, boundary, configuration
	logic                bypass_q;
	logic [31:0]         id_sr_q;
	logic [BSR_LEN-1:0]  bsr_sr_q;
	logic [CFG_DR_W-1:0] cfg_sr_q;
	always_ff @(posedge tck or negedge resetn) begin
		if (!resetn) begin
			bypass_q <= 1'b0;
			id_sr_q  <= 32'h0000_0000;
			bsr_sr_q <= '0;
			cfg_sr_q <= '0;
		end else if (ctl.cap_dr) begin
			bypass_q <= 1'b0;
			id_sr_q  <= ID_VALUE;
			bsr_sr_q <= bsr_pins_in;
			cfg_sr_q <= {{(CFG_DR_W-8){1'b0}}, st_s2_q};
		end else if (ctl.sh_dr) begin
			unique case (dr_sel)
				cap_pkg::DR_BYPASS: bypass_q <= tdi;
				cap_pkg::DR_ID:     id_sr_q  <= {tdi, id_sr_q[31:1]};
				cap_pkg::DR_BSR:
					bsr_sr_q <= {tdi, bsr_sr_q[BSR_LEN-1:1]};
				cap_pkg::DR_CFG:
					cfg_sr_q <= {tdi, cfg_sr_q[CFG_DR_W-1:1]};
			endcase
		end
	end

	// Update stage: boundary latch and config byte handed to fabric
	always_ff @(posedge tck or negedge resetn) begin
		if (!resetn) begin
			bsr_update <= '0;
			jtg_tog_q  <= 1'b0;
			jtg_hold_q <= 8'h00;
		end else if (ctl.upd_dr) begin
			if (dr_sel == cap_pkg::DR_BSR) begin
				bsr_update <= bsr_sr_q;
			end
			if (ir_q == cap_pkg::OP_CFG_IN) begin
				jtg_hold_q <= cfg_sr_q[7:0];
				jtg_tog_q  <= !jtg_tog_q;
			end
		end
	end

	// Serial output source from state and instruction
	logic tdo_d;
	always_comb begin
		unique case (dr_sel)
			cap_pkg::DR_BYPASS: tdo_d = bypass_q;
			cap_pkg::DR_ID:     tdo_d = id_sr_q[0];
			cap_pkg::DR_BSR:    tdo_d = bsr_sr_q[0];
			cap_pkg::DR_CFG:    tdo_d = cfg_sr_q[0];
		endcase
		if (ctl.sh_ir) begin
			tdo_d = ir_sr_q[0];
		end
	end

	// Falling-edge output keeps hold time for the tester's rising edge
	always_ff @(negedge tck or negedge resetn) begin
		if (!resetn) begin
			tdo_o  <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo_o  <= tdo_d;
			tdo_oe <= ctl.sh_ir || ctl.sh_dr;
		end
	end

	AST_TDO_ONLY_SHIFT: assert property (@(posedge tck)
		disable iff (!resetn)
		tdo_oe == (ctl.sh_ir || ctl.sh_dr))
		else $error("serial output enable outside shifting");

	AST_IR_TDO: assert property (@(posedge tck)
		disable iff (!resetn) ctl.sh_ir |-> tdo_o == ir_sr_q[0])
		else $error("instruction bit not on serial output");

	AST_IR_TAKES_TDI: assert property (@(posedge tck)
		disable iff (!resetn)
		ctl.sh_ir |=> ir_sr_q[cap_pkg::IR_W-1] == $past(tdi))
		else $error("serial input not shifted into instruction");

	AST_RESET_IDENT: assert property (@(posedge tck)
		disable iff (!resetn) ctl.tlr |=> ir_q == cap_pkg::OP_IDCODE)
		else $error("identification not selected after reset");

	AST_BYPASS_CAPTURE: assert property (@(posedge tck)
		disable iff (!resetn)
		ctl.cap_dr |=> !bypass_q)
		else $error("bypass not cleared on capture");

endmodule

// ===== tb/cap_tester.sv
// Boundary-scan tester model standing outside the test port.
// Assumes the device samples tms/tdi on rising tck and moves tdo on falling.
`timescale 1ns/1ps
module cap_tester (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo_o,
	input  wire logic tdo_oe
);
	// Clock parked low between scans; idle lines sit at their pull-up level
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// One test-clock period of 80 ns; tdo is read as the wire shows it
	task automatic bitx(input logic m, input logic d, output logic q,
		output logic oe, output logic moved);
		logic v;
		tms = m;
		tdi = d;
		#40;
		v = tdo_o;
		oe = tdo_oe;
		q = tdo_oe ? tdo_o : 1'b1; // Pull-up when released
		tck = 1'b1;
		#20;
		moved = (tdo_o !== v);
		#20;
		tck = 1'b0;
	endtask
endmodule

// ===== tb/test_cap_top.sv
// Self-checking bench for the configuration access ports.
// Assumes a 100 MHz fabric clock and an 80 ns test clock from the tester.
`timescale 1ns/1ps
module test_cap_top;
	localparam logic [31:0] TB_ID = 32'h0000_0F01; // Arbitrary value
	logic                  clock;
	logic                  resetn;
	logic                  config_done;
	logic                  retain_external_port_bit;
	logic                  ext_port_enable;
	logic                  tck;
	logic                  tms;
	logic                  tdi;
	logic                  tdo_o;
	logic                  tdo_oe;
	logic [7:0]            bsr_pins_in;
	logic [7:0]            bsr_update;
	logic [31:0]           d;
	logic [7:0]            wb [3];
	int                    err_count;
	int                    n_tests;
	int                    cyc;
	int                    nb;
	cap_pkg::cap_cfg_req_s cfg_req;
	cap_pkg::cap_cfg_rsp_s cfg_rsp;

	cap_top #(.BSR_LEN(8), .ID_VALUE(TB_ID)) dut (
		.clock(clock), .resetn(resetn), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
		.config_done(config_done),
		.retain_external_port_bit(retain_external_port_bit),
		.ext_port_enable(ext_port_enable), .tck(tck), .tms(tms), .tdi(tdi),
		.tdo_o(tdo_o), .tdo_oe(tdo_oe), .bsr_pins_in(bsr_pins_in),
		.bsr_update(bsr_update)
	);
	cap_tester u_tst (
		.tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe)
	);

	// Fabric clock
	initial clock = 1'b0;
	always #5 clock = ~clock;

	// Hang guard: the whole sequence needs well under 10000 cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end

	task automatic chk(input logic ok, input string m);
		n_tests++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// From idle: walk to shift, move n bits LSB first, update, back to idle
	// Bits past the 32-bit word shift in zeros and are not kept
	task automatic scan(input logic ir, input logic [31:0] din, input int n,
		output logic [31:0] dout);
		logic q, oe, mv;
		dout = '0;
		#3;
		u_tst.bitx(1'b1, 1'b1, q, oe, mv);
		if (ir) u_tst.bitx(1'b1, 1'b1, q, oe, mv);
		u_tst.bitx(1'b0, 1'b1, q, oe, mv);
		u_tst.bitx(1'b0, 1'b1, q, oe, mv);
		for (int i = 0; i < n; i++) begin
			u_tst.bitx(i == n - 1, (i < 32) ? din[i] : 1'b0, q, oe,
				mv);
			if (i < 32) begin
				dout[i] = q;
			end
			chk(oe === 1'b1 && mv === 1'b0, "tdo idle or moved on rise");
		end
		u_tst.bitx(1'b1, 1'b1, q, oe, mv);
		u_tst.bitx(1'b0, 1'b1, q, oe, mv);
		chk(oe === 1'b0, "tdo driven outside shift");
	endtask

	// Short instruction scan leaves a bypass code; five high edges reset
	task automatic test_tap_reset();
		logic q, oe, mv;
		#3;
		u_tst.bitx(1'b0, 1'b1, q, oe, mv);
		scan(1'b0, 32'h0, 32, d);
		chk(d === TB_ID, "power-up id");
		scan(1'b1, 32'h3F, 3, d);
		repeat (5) u_tst.bitx(1'b1, 1'b1, q, oe, mv);
		u_tst.bitx(1'b0, 1'b1, q, oe, mv);
		scan(1'b0, 32'h0, 32, d);
		chk(d === TB_ID, "id after reset walk");
		$display("test_tap_reset done");
	endtask

	task automatic test_ir_bypass();
		scan(1'b1, 32'h3F, 6, d);
		chk(d[5:0] === cap_pkg::IR_CAPTURE, "ir capture");
		scan(1'b0, 32'hA5, 8, d);
		chk(d[7:0] === 8'h4A, "bypass delay");
		scan(1'b1, 32'h2A, 6, d);
		scan(1'b0, 32'h1, 2, d);
		chk(d[1:0] === 2'b10, "unknown code bypass");
		$display("test_ir_bypass done");
	endtask

	task automatic test_bsr();
		bsr_pins_in = 8'h3C;
		scan(1'b1, 32'(cap_pkg::OP_SAMPLE), 6, d);
		scan(1'b0, 32'hC3, 8, d);
		chk(d[7:0] === 8'h3C, "boundary capture");
		chk(bsr_update === 8'hC3, "boundary update");
		$display("test_bsr done");
	endtask

	// Select at a falling edge, then count busy cycles up to ready
	task automatic port_sel(input logic rnw, input logic [7:0] wd);
		@(negedge clock);
		cfg_req = '{sel_n: 1'b0, read_not_write: rnw, wdata: wd};
		nb = 0;
		@(negedge clock);
		while (cfg_rsp.busy === 1'b1 && nb < 20) begin
			nb++;
			@(negedge clock);
		end
		chk(nb == cap_pkg::BUSY_CYC, "busy length");
	endtask

	task automatic port_off();
		@(negedge clock);
		cfg_req.sel_n = 1'b1;
		#1;
		chk(cfg_rsp === '0, "outputs not released");
	endtask

	task automatic test_write_read();
		wb = '{8'h5A, 8'hC3, 8'h0F};
		port_sel(1'b0, wb[0]);
		for (int i = 1; i < 3; i++) begin
			@(negedge clock);
			cfg_req.wdata = wb[i];
		end
		port_off();
		port_sel(1'b1, 8'h00);
		for (int i = 0; i < 3; i++) begin
			@(negedge clock);
			chk(cfg_rsp.rdata === wb[i], "read byte");
		end
		port_off();
		$display("test_write_read done");
	endtask

	// Direction flipped to read while selected in write starts an abort
	task automatic test_abort();
		port_sel(1'b0, 8'h11);
		cfg_req.read_not_write = 1'b1;
		@(negedge clock);
		chk(cfg_rsp.busy === 1'b1, "abort busy");
		@(negedge clock); // Status byte is registered, one cycle behind
		chk(cfg_rsp.busy === 1'b1, "abort busy held");
		chk(cfg_rsp.rdata[7] === 1'b1 && cfg_rsp.rdata[4] === 1'b0 &&
			cfg_rsp.rdata[3:0] === 4'hF, "abort status");
		port_off();
		repeat (8) @(negedge clock);
		$display("test_abort done");
	endtask

	task automatic test_fence();
		repeat (3) @(negedge clock);
		chk(ext_port_enable === 1'b1, "external port before done");
		config_done = 1'b1;
		retain_external_port_bit = 1'b1;
		repeat (4) @(negedge clock);
		chk(ext_port_enable === 1'b1, "external port retained");
		cfg_req = '{sel_n: 1'b0, read_not_write: 1'b1, wdata: 8'h00};
		repeat (5) begin
			@(negedge clock);
			chk(cfg_rsp.busy === 1'b0, "internal port not fenced");
		end
		port_off();
		retain_external_port_bit = 1'b0;
		repeat (4) @(negedge clock);
		chk(ext_port_enable === 1'b0, "external port after done");
		port_sel(1'b0, 8'h00);
		port_off();
		$display("test_fence done");
	endtask

	// Config register: status on capture, and a byte sent into the store
	task automatic test_cfg();
		scan(1'b1, 32'(cap_pkg::OP_CFG_OUT), 6, d);
		scan(1'b0, 32'h0, 8, d);
		chk(d[7] === 1'b1 && d[5:0] === 6'h1F, "config status");
		scan(1'b1, 32'(cap_pkg::OP_CFG_IN), 6, d);
		scan(1'b0, 32'h96, 64, d);
		port_sel(1'b1, 8'h00);
		@(negedge clock);
		chk(cfg_rsp.rdata === 8'h96, "config byte from test port");
		port_off();
		$display("test_cfg done");
	endtask

	initial begin
		resetn = 1'b0;
		config_done = 1'b0;
		retain_external_port_bit = 1'b0;
		bsr_pins_in = 8'h00;
		cfg_req = '{sel_n: 1'b1, read_not_write: 1'b0, wdata: 8'h00};
		repeat (3) @(negedge clock);
		resetn = 1'b1;
		test_tap_reset();
		test_ir_bypass();
		test_bsr();
		test_write_read();
		test_abort();
		test_fence();
		test_cfg();
		finish_test();
	end
endmodule
